// ---- ioc_defs.svh ----
// register offsets, field limits, reset values and sizes for the pin change detector
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH
`define PORTA_RISE_ENABLE_OFS 12'h000
`define PORTA_FALL_ENABLE_OFS 12'h004
`define PORTA_CHANGE_FLAGS_OFS 12'h008
`define PORTB_RISE_ENABLE_OFS 12'h00C
`define PORTB_FALL_ENABLE_OFS 12'h010
`define PORTB_CHANGE_FLAGS_OFS 12'h014
`define PORTC_RISE_ENABLE_OFS 12'h018
`define PORTC_FALL_ENABLE_OFS 12'h01C
`define PORTC_CHANGE_FLAGS_OFS 12'h020
`define CHANGE_CTRL_OFS 12'h024
`define CHANGE_CTRL_IRQ_ENABLE_BIT 0
`define CHANGE_CTRL_IRQ_FLAG_BIT 1
`define CHANGE_CTRL_SLEEP_BIT 2
`define PORTA_MASK 8'h3F
`define PORTB_MASK 8'hF0
`define PORTC_MASK_LARGE 8'hFF
`define PORTC_MASK_SMALL 8'h3F
`define PORT_RESET 8'h00
`define PORT_WIDTH 8
`define PORT_COUNT 3
`endif

// ---- ioc_pkg.sv ----
// types shared by the pin change detector files
package ioc_pkg;
    typedef logic [7:0] port_byte_t;
    typedef enum logic [1:0]
    {
        port_a = 2'b00,
        port_b = 2'b01,
        port_c = 2'b10
    } port_sel_t;
    typedef enum logic [0:0]
    {
        st_run = 1'b0,
        st_sleep = 1'b1
    } power_state_t;
endpackage : ioc_pkg

// ---- edge_if.sv ----
// per-port bundle between the top and the edge detector
`timescale 1ns/100ps
interface edge_if;
    logic [7:0] pins;
    logic [7:0] rise_hit;
    logic [7:0] fall_hit;
    modport detector (input pins, output rise_hit, output fall_hit);
    modport user (output pins, input rise_hit, input fall_hit);
endinterface : edge_if

// ---- edge_detect.sv ----
// three-stage pin synchroniser and per-bit edge detection for one port
`timescale 1ns/100ps
module edge_detect
    import ioc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    edge_if.detector port
);
    genvar i;
    // =========================================================
    // synchroniser and edge compare
    generate
        for (i = 0; i < 8; i++)
        begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            // level is accepted once stages two and three agree
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    lvl_reg <= 1'b0;
                end
                else
                begin
                    s1_reg <= port.pins[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg)
                        lvl_reg <= s3_reg; // RULE_12
                end
            end
            // a new accepted level against the old one is an edge
            assign port.rise_hit[i] = (s2_reg == s3_reg) && s3_reg && !lvl_reg; // RULE_12
            assign port.fall_hit[i] = (s2_reg == s3_reg) && !s3_reg && lvl_reg; // RULE_12
        end
    endgenerate
endmodule : edge_detect

// ---- pin_change_edge_detector.sv ----
// APB pin change edge detector for ports A, B and C
// Operation
// RULE_01: enabled falling edge sets pin and shared flag
// RULE_02: disabled falling edge is ignored
// RULE_03: flag set by enabled rise or fall
// RULE_04: flags stay set until software writes zero
// RULE_05: enables and flags reset to zero
// RULE_06: port C top two bits on large variant
// RULE_07: unimplemented bits ignore writes, read zero
// RULE_08: edge during clear keeps flag set
// RULE_09: enabled edge wakes from sleep when enabled
// RULE_10: sleep edge recorded before first instruction
// RULE_11: enabled rising edge sets pin and shared flag
// RULE_12: pins synchronised, edges by level compare
`timescale 1ns/100ps
`include "ioc_defs.svh"
module pin_change_edge_detector
    import ioc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] porta_pin,
    input wire logic [7:0] portb_pin,
    input wire logic [7:0] portc_pin,
    input wire logic sleep_req,
    output logic change_irq,
    output logic wake_up,
    output logic asleep
);
    // =========================================================
    // port masks
    // the two top port C bits exist only on the larger variant
    localparam port_byte_t MASK_C = LARGE_VARIANT ? `PORTC_MASK_LARGE
                                                 : `PORTC_MASK_SMALL; // RULE_06
    localparam port_byte_t MASK_A = `PORTA_MASK;
    localparam port_byte_t MASK_B = `PORTB_MASK;

    // =========================================================
    // edge detectors, one per port
    edge_if if_a ();
    edge_if if_b ();
    edge_if if_c ();
    assign if_a.pins = porta_pin;
    assign if_b.pins = portb_pin;
    assign if_c.pins = portc_pin;
    edge_detect u_det_a (.pclk(pclk), .presetn(presetn), .port(if_a.detector));
    edge_detect u_det_b (.pclk(pclk), .presetn(presetn), .port(if_b.detector));
    edge_detect u_det_c (.pclk(pclk), .presetn(presetn), .port(if_c.detector));

    // =========================================================
    // registers
    port_byte_t porta_rise_enable_reg;
    port_byte_t porta_fall_enable_reg;
    port_byte_t porta_change_flags_reg;
    port_byte_t portb_rise_enable_reg;
    port_byte_t portb_fall_enable_reg;
    port_byte_t portb_change_flags_reg;
    port_byte_t portc_rise_enable_reg;
    port_byte_t portc_fall_enable_reg;
    port_byte_t portc_change_flags_reg;
    logic change_irq_enable_reg;
    power_state_t state_reg;
    power_state_t state_next;

    // =========================================================
    // bus decode
    wire access_w = psel && penable;
    wire wr_w = access_w && pwrite && pstrb[0];
    wire hit_ar = paddr == `PORTA_RISE_ENABLE_OFS;
    wire hit_af = paddr == `PORTA_FALL_ENABLE_OFS;
    wire hit_ac = paddr == `PORTA_CHANGE_FLAGS_OFS;
    wire hit_br = paddr == `PORTB_RISE_ENABLE_OFS;
    wire hit_bf = paddr == `PORTB_FALL_ENABLE_OFS;
    wire hit_bc = paddr == `PORTB_CHANGE_FLAGS_OFS;
    wire hit_cr = paddr == `PORTC_RISE_ENABLE_OFS;
    wire hit_cf = paddr == `PORTC_FALL_ENABLE_OFS;
    wire hit_cc = paddr == `PORTC_CHANGE_FLAGS_OFS;
    wire hit_ctl = paddr == `CHANGE_CTRL_OFS;
    wire mapped_w = hit_ar | hit_af | hit_ac | hit_br | hit_bf | hit_bc
                  | hit_cr | hit_cf | hit_cc | hit_ctl;
    wire [7:0] wbyte = pwdata[7:0];

    // =========================================================
    // enabled edges per port
    wire [7:0] ev_a = ((if_a.rise_hit & porta_rise_enable_reg)
                    | (if_a.fall_hit & porta_fall_enable_reg)) & MASK_A;
    wire [7:0] ev_b = ((if_b.rise_hit & portb_rise_enable_reg)
                    | (if_b.fall_hit & portb_fall_enable_reg)) & MASK_B;
    // only enabled edges reach port C flags; a zero enable hides that edge
    wire [7:0] ev_c = ((if_c.rise_hit & portc_rise_enable_reg) // RULE_11
                    | (if_c.fall_hit & portc_fall_enable_reg)) & MASK_C; // RULE_01 RULE_02 RULE_03

    // =========================================================
    // next flag values: software clears by writing zero, hardware set wins
    wire [7:0] fa_keep = (wr_w && hit_ac) ? (porta_change_flags_reg & wbyte)
                                          : porta_change_flags_reg;
    wire [7:0] fb_keep = (wr_w && hit_bc) ? (portb_change_flags_reg & wbyte)
                                          : portb_change_flags_reg;
    wire [7:0] fc_keep = (wr_w && hit_cc) ? (portc_change_flags_reg & wbyte) // RULE_04
                                          : portc_change_flags_reg;
    wire [7:0] fa_next = (fa_keep | ev_a) & MASK_A;
    wire [7:0] fb_next = (fb_keep | ev_b) & MASK_B;
    wire [7:0] fc_next = (fc_keep | ev_c) & MASK_C; // RULE_08
    wire any_event = |{ev_a, ev_b, ev_c};

    // =========================================================
    // enable registers; masks keep unimplemented bits at zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_rise_enable_reg <= `PORT_RESET;
            porta_fall_enable_reg <= `PORT_RESET;
            portb_rise_enable_reg <= `PORT_RESET;
            portb_fall_enable_reg <= `PORT_RESET;
            portc_rise_enable_reg <= `PORT_RESET; // RULE_05
            portc_fall_enable_reg <= `PORT_RESET; // RULE_05
            change_irq_enable_reg <= 1'b0;
        end
        else if (wr_w)
        begin
            if (hit_ar) porta_rise_enable_reg <= wbyte & MASK_A;
            if (hit_af) porta_fall_enable_reg <= wbyte & MASK_A;
            if (hit_br) portb_rise_enable_reg <= wbyte & MASK_B;
            if (hit_bf) portb_fall_enable_reg <= wbyte & MASK_B;
            if (hit_cr) portc_rise_enable_reg <= wbyte & MASK_C; // RULE_07
            if (hit_cf) portc_fall_enable_reg <= wbyte & MASK_C; // RULE_07
            if (hit_ctl) change_irq_enable_reg <= pwdata[`CHANGE_CTRL_IRQ_ENABLE_BIT];
        end
    end

    // =========================================================
    // flag registers; they run during sleep so edges are caught at once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_change_flags_reg <= `PORT_RESET;
            portb_change_flags_reg <= `PORT_RESET;
            portc_change_flags_reg <= `PORT_RESET; // RULE_05
        end
        else
        begin
            porta_change_flags_reg <= fa_next;
            portb_change_flags_reg <= fb_next;
            portc_change_flags_reg <= fc_next; // RULE_10
        end
    end

    // =========================================================
    // sleep state: wake comes with the flag update in the same edge
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            st_run:
                if (sleep_req && !(change_irq_enable_reg && any_event))
                    state_next = st_sleep;
            st_sleep:
                if (change_irq_enable_reg && any_event)
                    state_next = st_run; // RULE_09
            default:
                state_next = st_run;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= st_run;
            asleep <= 1'b0;
            wake_up <= 1'b0;
            change_irq <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            asleep <= state_next == st_sleep;
            wake_up <= (state_reg == st_sleep) && (state_next == st_run); // RULE_09
            change_irq <= change_irq_enable_reg && (|{fa_next, fb_next, fc_next});
        end
    end

    // =========================================================
    // read mux; the shared flag is the or of all pin flags
    wire shared_flag = |{porta_change_flags_reg, portb_change_flags_reg,
                         portc_change_flags_reg};
    wire [7:0] ctl_rd = {5'h00, state_reg == st_sleep, shared_flag, change_irq_enable_reg};
    wire [7:0] rd_byte =
        hit_ar ? porta_rise_enable_reg :
        hit_af ? porta_fall_enable_reg :
        hit_ac ? porta_change_flags_reg :
        hit_br ? portb_rise_enable_reg :
        hit_bf ? portb_fall_enable_reg :
        hit_bc ? portb_change_flags_reg :
        hit_cr ? portc_rise_enable_reg :
        hit_cf ? portc_fall_enable_reg :
        hit_cc ? portc_change_flags_reg :
        hit_ctl ? ctl_rd : 8'h00;

    // answer registered in the setup cycle so the access phase is one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped_w;
            prdata <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // =========================================================
    // checks
    a_fall_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (if_c.fall_hit[0] && portc_fall_enable_reg[0]) |=> portc_change_flags_reg[0])
        else $error("enabled falling edge missed"); // RULE_01
    // falling edges on clear flags whose fall enable is off, on any port C pin
    wire [7:0] fall_off_c = if_c.fall_hit & ~portc_fall_enable_reg & ~portc_change_flags_reg;
    a_fall_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        (fall_off_c != 8'h00) |=> ((portc_change_flags_reg & $past(fall_off_c)) == 8'h00))
        else $error("flag set without enable"); // RULE_02
    a_rise_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (if_c.rise_hit[1] && portc_rise_enable_reg[1]) |=> portc_change_flags_reg[1])
        else $error("enabled rising edge missed"); // RULE_11
    a_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
        ((portc_change_flags_reg & ~$past(portc_change_flags_reg) & ~$past(ev_c)) == 8'h00))
        else $error("flag rose without edge"); // RULE_03
    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_w && hit_cc) |=>
        ((portc_change_flags_reg & $past(portc_change_flags_reg)) == $past(portc_change_flags_reg)))
        else $error("flag dropped without clear"); // RULE_04
    a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_w && hit_cc && (ev_c != 8'h00)) |=> ((portc_change_flags_reg & $past(ev_c)) == $past(ev_c)))
        else $error("edge lost during clear"); // RULE_08
    a_unimpl_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ((porta_change_flags_reg & ~MASK_A) == 8'h00)
        && ((portc_rise_enable_reg & ~MASK_C) == 8'h00))
        else $error("unimplemented bit set"); // RULE_07 RULE_06
    sequence s_sleep_edge;
        (state_reg == st_sleep) && change_irq_enable_reg && any_event;
    endsequence
    a_wake_sleep: assert property (@(posedge pclk) disable iff (!presetn)
        s_sleep_edge |=> wake_up && !asleep && shared_flag)
        else $error("no wake with flag"); // RULE_09 RULE_10
    a_reset_clear: assert property (@(posedge pclk)
        !presetn |-> portc_change_flags_reg == 8'h00)
        else $error("flags not reset"); // RULE_05
endmodule : pin_change_edge_detector

// ---- pin_change_edge_detector_tb.sv ----
// self-checking testbench for the APB pin change edge detector
`timescale 1ns/100ps
`include "ioc_defs.svh"
module pin_change_edge_detector_tb;
    // ==========================================================
    // signals and design
    logic pclk = 1'b0;
    logic presetn = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] portc_pin = 8'h00;
    logic sleep_req = 1'b0;
    logic change_irq;
    logic wake_up;
    logic asleep;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [11:0] offs [0:9];
    logic [7:0] masks [0:5];

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // ports A and B tied low: the port C path carries the edge scenarios
    pin_change_edge_detector #(.LARGE_VARIANT(1'b1)) i_dut
    (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(4'hF),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .porta_pin(8'h00),
        .portb_pin(8'h00),
        .portc_pin(portc_pin),
        .sleep_req(sleep_req),
        .change_irq(change_irq),
        .wake_up(wake_up),
        .asleep(asleep)
    );

    // ==========================================================
    // reporting
    task automatic test_done;
        if (n_mismatch == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    task automatic check_data(input logic [31:0] act, input logic [31:0] exp);
        tests_run++;
        if (act !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check_data

    task automatic check_bit(input logic act, input logic exp);
        tests_run++;
        if (act !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask : check_bit

    // ==========================================================
    // apb master: request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, data and response are all taken at the same rising edge
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            test_done();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] addr, input logic [7:0] data);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, {24'h000000, data}, rd, err);
    endtask : wr

    task automatic rd_check(input logic [11:0] addr, input logic [7:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 32'h00000000, rd, err);
        check_data(rd, {24'h000000, exp});
        check_bit(err, exp_err);
    endtask : rd_check

    // wait on a design level with a bound; running out ends the run
    task automatic wait_high(input int which);
        int i;
        for (i = 0; i < 40 && (which == 0 ? asleep : wake_up) !== 1'b1; i++)
            @(negedge pclk);
        if (i == 40)
        begin
            n_mismatch++;
            test_done();
        end
    endtask : wait_high

    // ==========================================================
    // main sequence
    initial
    begin
        // a real falling edge so the asynchronous reset branches run at once
        presetn <= 1'b0;
        offs = '{`PORTA_RISE_ENABLE_OFS, `PORTA_FALL_ENABLE_OFS, `PORTB_RISE_ENABLE_OFS,
                 `PORTB_FALL_ENABLE_OFS, `PORTC_RISE_ENABLE_OFS, `PORTC_FALL_ENABLE_OFS,
                 `PORTA_CHANGE_FLAGS_OFS, `PORTB_CHANGE_FLAGS_OFS, `PORTC_CHANGE_FLAGS_OFS,
                 `CHANGE_CTRL_OFS};
        masks = '{8'h3F, 8'h3F, 8'hF0, 8'hF0, 8'hFF, 8'hFF};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        // every register clears on reset
        for (int k = 0; k < 10; k++)
            rd_check(offs[k], 8'h00, 1'b0);
        check_bit(change_irq, 1'b0);
        // unimplemented enable bits drop writes and read zero
        for (int k = 0; k < 6; k++)
        begin
            wr(offs[k], 8'hFF);
            rd_check(offs[k], masks[k], 1'b0);
        end
        rd_check(`PORTC_RISE_ENABLE_OFS, 8'hFF, 1'b0);
        for (int k = 0; k < 6; k++)
            wr(offs[k], 8'h00);
        // unmapped place: error, no effect
        wr(12'h028, 8'hFF);
        rd_check(12'h028, 8'h00, 1'b1);
        // rising edges on all pins, only enabled ones flag
        wr(`PORTC_RISE_ENABLE_OFS, 8'h82);
        wr(`PORTC_FALL_ENABLE_OFS, 8'h41);
        @(posedge pclk);
        portc_pin <= 8'hFF;
        repeat (8) @(posedge pclk);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h82, 1'b0);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'hFF);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h82, 1'b0);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'h02);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h02, 1'b0);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'h00);
        // falling edges: bits with fall enable clear stay quiet
        @(posedge pclk);
        portc_pin <= 8'h00;
        repeat (8) @(posedge pclk);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h41, 1'b0);
        rd_check(`CHANGE_CTRL_OFS, 8'h02, 1'b0);
        check_bit(change_irq, 1'b0);
        wr(`CHANGE_CTRL_OFS, 8'h01);
        rd_check(`CHANGE_CTRL_OFS, 8'h03, 1'b0);
        check_bit(change_irq, 1'b1);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'h00);
        rd_check(`CHANGE_CTRL_OFS, 8'h01, 1'b0);
        check_bit(change_irq, 1'b0);
        // edge arriving while software clears: the flag must survive
        @(posedge pclk);
        portc_pin <= 8'h02;
        @(posedge pclk);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'h00);
        repeat (4) @(posedge pclk);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h02, 1'b0);
        wr(`PORTC_CHANGE_FLAGS_OFS, 8'h00);
        // sleep, then wake on an enabled falling edge of pin 1
        wr(`PORTC_FALL_ENABLE_OFS, 8'h02);
        @(posedge pclk);
        sleep_req <= 1'b1;
        wait_high(0);
        rd_check(`CHANGE_CTRL_OFS, 8'h05, 1'b0);
        // once asleep the state holds by itself, so the request may drop
        sleep_req <= 1'b0;
        @(posedge pclk);
        portc_pin <= 8'h00;
        @(negedge pclk);
        wait_high(1);
        check_bit(asleep, 1'b0);
        @(negedge pclk);
        check_bit(wake_up, 1'b0);
        check_bit(asleep, 1'b0);
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h02, 1'b0);
        rd_check(`CHANGE_CTRL_OFS, 8'h03, 1'b0);
        // a reset in mid-run clears enables and flags again
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_check(`PORTC_CHANGE_FLAGS_OFS, 8'h00, 1'b0);
        rd_check(`PORTC_FALL_ENABLE_OFS, 8'h00, 1'b0);
        rd_check(`CHANGE_CTRL_OFS, 8'h00, 1'b0);
        test_done();
    end
endmodule : pin_change_edge_detector_tb
